// File: dfpc_pkg.sv
// dfpc_pkg: constants and carrier types for the digital frequency pull control
// assumes: register port of 2-bit address, 16-bit data, one-cycle strobes
`default_nettype none

package dfpc_pkg;

    //------------------------------------------------------------
    // register offsets
    //------------------------------------------------------------
    localparam logic [1:0] ADDR_WORD_LOW  = 2'h0;
    localparam logic [1:0] ADDR_WORD_HIGH = 2'h1;
    localparam logic [1:0] ADDR_RANGE_SEL = 2'h2;

    //------------------------------------------------------------
    // field layout
    //------------------------------------------------------------
    localparam int WORD_W      = 26;
    localparam int LOW_W       = 16;
    localparam int HIGH_W      = 10;
    localparam int OE_BIT      = 10;
    localparam int RANGE_W     = 4;
    localparam int PPM_W       = 16;
    localparam int OFFSET_W    = 32;

    //------------------------------------------------------------
    // reset values
    //------------------------------------------------------------
    localparam logic [15:0] LOW_RESET  = 16'h0000;
    localparam logic [9:0]  HIGH_RESET = 10'h000;
    localparam logic        OE_RESET   = 1'b0;

    // full-scale word, 2^25-1
    localparam logic [31:0] FULL_SCALE = 32'h01FF_FFFF;

    //------------------------------------------------------------
    // update pacing: 38 kHz at 100 MHz clock
    //------------------------------------------------------------
    localparam int CLK_HZ         = 100_000_000;
    localparam int UPDATE_MAX_HZ  = 38_000;
    localparam int UPDATE_CYCLES  = (CLK_HZ + UPDATE_MAX_HZ - 1)
                                    / UPDATE_MAX_HZ;

    //------------------------------------------------------------
    // register access carrier, writes and reads
    //------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  addr;
        logic [15:0] wdata;
    } dfpc_req_type;

    typedef enum {
        ST_IDLE,
        ST_PACE
    } dfpc_state_type;

endpackage : dfpc_pkg

`default_nettype wire

// File: dfpc_top.sv
// dfpc_top: frequency control word, pull range and soft output enable
// assumes: register strobes from an external serial engine, one per access
`timescale 1ns/1ps
`default_nettype none

module dfpc_top #(
    parameter logic [3:0] FACTORY_RANGE = 4'h9,   // preset selector
    parameter int         PACE_CYCLES   = dfpc_pkg::UPDATE_CYCLES
) (
    input  wire logic                 clock_in,      // 100 MHz
    input  wire logic                 srst_in,       // sync reset, high
    input  wire dfpc_pkg::dfpc_req_type req_in,      // register access
    input  wire logic                 oe_pin_mode_in, // 1: pin owns enable
    input  wire logic                 oe_pin_in,     // enable pin level
    output logic [15:0]               rdata_out,     // read data
    output logic                      rvalid_out,    // read data valid
    output logic [25:0]               word_out,      // applied word
    output logic [3:0]                range_sel_out, // applied selector
    output logic [31:0]               offset_out,    // offset, 1e-4 ppm
    output logic                      out_en_out,    // clock output on
    output logic                      update_out,    // new word applied
    output logic                      busy_out       // pacing window open
);

    //----------------------------------------------------------------
    // range lookup, units of 0.01 ppm half range
    //----------------------------------------------------------------
    function automatic logic [31:0] half_range(input logic [3:0] sel);
        case (sel)
            4'h0:    half_range = 32'h0000_0271;   // 6.25
            4'h1:    half_range = 32'h0000_03E8;   // 10
            4'h2:    half_range = 32'h0000_04E2;   // 12.5
            4'h3:    half_range = 32'h0000_09C4;   // 25
            4'h4:    half_range = 32'h0000_1388;   // 50
            4'h5:    half_range = 32'h0000_1F40;   // 80
            4'h6:    half_range = 32'h0000_2710;   // 100
            4'h7:    half_range = 32'h0000_30D4;   // 125
            4'h8:    half_range = 32'h0000_3A98;   // 150
            4'h9:    half_range = 32'h0000_4E20;   // 200
            4'hA:    half_range = 32'h0000_9C40;   // 400
            4'hB:    half_range = 32'h0000_EA60;   // 600
            4'hC:    half_range = 32'h0001_3880;   // 800
            4'hD:    half_range = 32'h0001_D4C0;   // 1200
            4'hE:    half_range = 32'h0002_7100;   // 1600
            default: half_range = 32'h0004_E200;   // 3200
        endcase
    endfunction

    //----------------------------------------------------------------
    // registers
    //----------------------------------------------------------------
    logic [15:0] low_r,    low_nxt;
    logic [9:0]  high_r,   high_nxt;
    logic        oe_r,     oe_nxt;
    logic [3:0]  sel_r,    sel_nxt;
    logic [25:0] word_r,   word_nxt;
    logic [3:0]  asel_r,   asel_nxt;
    logic [31:0] off_r,    off_nxt;
    logic [15:0] rdata_r,  rdata_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic        upd_r,    upd_nxt;
    logic        en_r,     en_nxt;
    logic [31:0] cnt_r,    cnt_nxt;
    dfpc_pkg::dfpc_state_type st_r, st_nxt;
    logic        pend_r,   pend_nxt;
    logic [25:0] pword_r,  pword_nxt;
    logic        busy_r,   busy_nxt;
    logic [31:0] gap_r,    gap_nxt;

    logic        wr_low, wr_high, wr_sel;
    logic [25:0] new_word;
    logic [57:0] prod;
    logic signed [57:0] scaled;

    assign wr_low  = req_in.wr && req_in.addr == dfpc_pkg::ADDR_WORD_LOW;
    assign wr_high = req_in.wr && req_in.addr == dfpc_pkg::ADDR_WORD_HIGH;
    assign wr_sel  = req_in.wr && req_in.addr == dfpc_pkg::ADDR_RANGE_SEL;
    assign new_word = {req_in.wdata[dfpc_pkg::HIGH_W-1:0], low_r};

    // signed scale: word * half range / full scale, units 1e-4 ppm
    // full-scale word lands exactly on range edge, so no overshoot
    always_comb begin
        prod   = 58'($signed(word_r)) * 58'(half_range(asel_r) * 32'd100);
        scaled = $signed(prod) / $signed(58'(dfpc_pkg::FULL_SCALE));
    end

    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        low_nxt    = low_r;
        high_nxt   = high_r;
        oe_nxt     = oe_r;
        sel_nxt    = sel_r;
        word_nxt   = word_r;
        asel_nxt   = sel_r;
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        pend_nxt   = pend_r;
        pword_nxt  = pword_r;
        upd_nxt    = 1'b0;
        rvalid_nxt = req_in.rd;
        rdata_nxt  = 16'h0000;
        if (wr_low)
            low_nxt = req_in.wdata;
        if (wr_sel)
            sel_nxt = req_in.wdata[dfpc_pkg::RANGE_W-1:0];
        if (wr_high) begin
            high_nxt = req_in.wdata[dfpc_pkg::HIGH_W-1:0];
            if (!oe_pin_mode_in)
                oe_nxt = req_in.wdata[dfpc_pkg::OE_BIT];
        end
        case (st_r)
            dfpc_pkg::ST_IDLE: begin
                if (wr_high) begin
                    word_nxt = new_word;
                    upd_nxt  = 1'b1;
                    st_nxt   = dfpc_pkg::ST_PACE;
                    cnt_nxt  = 32'(PACE_CYCLES - 1);
                end
            end
            dfpc_pkg::ST_PACE: begin
                // early high write kept whole, so a later low write cannot
                // leak into it; only the newest early write survives
                if (wr_high) begin
                    pend_nxt  = 1'b1;
                    pword_nxt = new_word;
                end
                if (cnt_r == 32'h0000_0000) begin
                    st_nxt = dfpc_pkg::ST_IDLE;
                    // a write on the closing cycle is taken at once
                    if (wr_high || pend_r) begin
                        word_nxt = wr_high ? new_word : pword_r;
                        upd_nxt  = 1'b1;
                        pend_nxt = 1'b0;
                        st_nxt   = dfpc_pkg::ST_PACE;
                        cnt_nxt  = 32'(PACE_CYCLES - 1);
                    end
                end else begin
                    cnt_nxt = cnt_r - 32'h0000_0001;
                end
            end
            default: st_nxt = dfpc_pkg::ST_IDLE;
        endcase
        case (req_in.addr)
            dfpc_pkg::ADDR_WORD_LOW:  rdata_nxt = low_r;
            dfpc_pkg::ADDR_WORD_HIGH: rdata_nxt = {5'h00, oe_r, high_r};
            dfpc_pkg::ADDR_RANGE_SEL: rdata_nxt = {12'h000, sel_r};
            default:                  rdata_nxt = 16'h0000;
        endcase
        off_nxt = scaled[31:0];
        en_nxt  = oe_pin_mode_in ? oe_pin_in : oe_r;
        busy_nxt = (st_nxt == dfpc_pkg::ST_PACE);
        // cycles since the last applied word, held once the window is met
        gap_nxt = gap_r;
        if (upd_r)
            gap_nxt = 32'h0000_0001;
        else if (gap_r < 32'(PACE_CYCLES))
            gap_nxt = gap_r + 32'h0000_0001;
    end

    //----------------------------------------------------------------
    // registers, reset gives nominal frequency and factory range
    //----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            low_r    <= dfpc_pkg::LOW_RESET;
            high_r   <= dfpc_pkg::HIGH_RESET;
            oe_r     <= dfpc_pkg::OE_RESET;
            sel_r    <= FACTORY_RANGE;
            asel_r   <= FACTORY_RANGE;
            word_r   <= {dfpc_pkg::HIGH_RESET, dfpc_pkg::LOW_RESET};
            off_r    <= 32'h0000_0000;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
            upd_r    <= 1'b0;
            en_r     <= 1'b0;
            cnt_r    <= 32'h0000_0000;
            st_r     <= dfpc_pkg::ST_IDLE;
            pend_r   <= 1'b0;
            pword_r  <= {dfpc_pkg::HIGH_RESET, dfpc_pkg::LOW_RESET};
            busy_r   <= 1'b0;
            gap_r    <= 32'(PACE_CYCLES);
        end else begin
            low_r    <= low_nxt;
            high_r   <= high_nxt;
            oe_r     <= oe_nxt;
            sel_r    <= sel_nxt;
            asel_r   <= asel_nxt;
            word_r   <= word_nxt;
            off_r    <= off_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            upd_r    <= upd_nxt;
            en_r     <= en_nxt;
            cnt_r    <= cnt_nxt;
            st_r     <= st_nxt;
            pend_r   <= pend_nxt;
            pword_r  <= pword_nxt;
            busy_r   <= busy_nxt;
            gap_r    <= gap_nxt;
        end
    end

    assign rdata_out     = rdata_r;
    assign rvalid_out    = rvalid_r;
    assign word_out      = word_r;
    assign range_sel_out = asel_r;
    assign offset_out    = off_r;
    assign out_en_out    = en_r;
    assign update_out    = upd_r;
    assign busy_out      = busy_r;

    //----------------------------------------------------------------
    // checks
    //----------------------------------------------------------------
    chk_low_no_apply: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (wr_low && st_r == dfpc_pkg::ST_IDLE) |=> !upd_r)
        else $error("low write applied a word");
    chk_high_apply: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (wr_high && st_r == dfpc_pkg::ST_IDLE)
        |=> upd_r && word_r == $past(new_word))
        else $error("high write not applied");
    chk_pace_gap: assert property (@(posedge clock_in)
        disable iff (srst_in)
        upd_r |-> !upd_nxt ##1 !upd_r)
        else $error("updates back to back");
    chk_pin_oe: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (wr_high && oe_pin_mode_in) |=> oe_r == $past(oe_r))
        else $error("enable bit moved under pin control");
    chk_soft_oe: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (wr_high && !oe_pin_mode_in)
        |=> oe_r == $past(req_in.wdata[dfpc_pkg::OE_BIT]))
        else $error("enable bit not written");
    chk_range_sel: assert property (@(posedge clock_in)
        disable iff (srst_in)
        wr_sel |=> ##1 asel_r == $past(req_in.wdata[3:0], 2))
        else $error("range not applied");
    chk_in_range: assert property (@(posedge clock_in)
        disable iff (srst_in)
        $signed(off_r) <= $signed(half_range($past(asel_r)) * 32'd100)
        && $signed(off_r) >= -$signed(half_range($past(asel_r)) * 32'd100))
        else $error("offset outside range");
    chk_reset_zero: assert property (@(posedge clock_in)
        disable iff (srst_in)
        $past(srst_in) |-> word_r == 26'h000_0000 && asel_r == FACTORY_RANGE)
        else $error("reset state wrong");
    chk_word_hold: assert property (@(posedge clock_in)
        disable iff (srst_in)
        !upd_r |-> word_r == $past(word_r))
        else $error("word moved without update");
    // spacing counter checks the window apart from the state machine
    chk_pace_spacing: assert property (@(posedge clock_in)
        disable iff (srst_in)
        upd_r |-> gap_r >= 32'(PACE_CYCLES))
        else $error("update inside pacing window");
    chk_busy_window: assert property (@(posedge clock_in)
        disable iff (srst_in)
        upd_r |-> busy_r)
        else $error("update without pacing window");
    chk_pend_keep: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (wr_high && st_r == dfpc_pkg::ST_PACE)
        |=> (pend_r && pword_r == $past(new_word))
            || (upd_r && word_r == $past(new_word)))
        else $error("early high write lost");
    chk_full_scale: assert property (@(posedge clock_in)
        disable iff (srst_in)
        $past(word_r) == 26'h1FF_FFFF
        |-> off_r == half_range($past(asel_r)) * 32'd100)
        else $error("full-scale word off range edge");
    chk_pin_enable: assert property (@(posedge clock_in)
        disable iff (srst_in)
        oe_pin_mode_in |=> en_r == $past(oe_pin_in))
        else $error("output enable not following pin");
    chk_rd_pulse: assert property (@(posedge clock_in)
        disable iff (srst_in)
        !$past(srst_in) |-> rvalid_r == $past(req_in.rd))
        else $error("read valid not one cycle after read");
    chk_sel_read: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (req_in.rd && req_in.addr == dfpc_pkg::ADDR_RANGE_SEL)
        |=> rdata_r == {12'h000, $past(sel_r)})
        else $error("selector read back wrong");
    chk_low_read: assert property (@(posedge clock_in)
        disable iff (srst_in)
        (req_in.rd && req_in.addr == dfpc_pkg::ADDR_WORD_LOW)
        |=> rdata_r == $past(low_r))
        else $error("low word read back wrong");

endmodule // dfpc_top

`default_nettype wire

// File: dfpc_host.sv
// dfpc_host: host-side model issuing single-cycle register accesses
// assumes: design samples req_in on the edge after it is driven
`timescale 1ns/1ps
`default_nettype none

module dfpc_host #(
    parameter int PACE = 4                        // update spacing, cycles
) (
    input  wire logic                  clock_in,  // system clock
    output var  dfpc_pkg::dfpc_req_type req_out   // access to design
);
    logic [15:0] last_d;

    initial req_out = '0;
    initial last_d = 16'h0000;

    task automatic put(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock_in);
        last_d = d;
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask

    task automatic get(input logic [1:0] a);
        @(posedge clock_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~last_d};
    endtask

    // released data flips so a stale value is never mistaken for fresh
    task automatic idle();
        @(posedge clock_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: 2'h3, wdata: ~last_d};
    endtask

    // low half first so the whole word is applied at once
    task automatic word(input logic [25:0] w, input logic oe);
        put(dfpc_pkg::ADDR_WORD_LOW, w[15:0]);
        put(dfpc_pkg::ADDR_WORD_HIGH, {5'h00, oe, w[25:16]});
        idle();
        repeat (PACE + 2) @(posedge clock_in);
    endtask
endmodule // dfpc_host

`default_nettype wire

// File: tb_dfpc.sv
// tb: self-checking bench for the frequency pull control block
// assumes: dfpc_host drives the register port; pacing shortened to 4
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int PACE = 4;
    localparam int HR [16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000,
        12500, 15000, 20000, 40000, 60000, 80000, 120000, 160000, 320000};
    logic                   clock_in = 1'b0;
    logic                   srst_in = 1'b1;
    logic                   oe_pin_mode_in = 1'b0;
    logic                   oe_pin_in = 1'b0;
    dfpc_pkg::dfpc_req_type req;
    logic [15:0]            rdata_out;
    logic                   rvalid_out;
    logic [25:0]            word_out;
    logic [3:0]             range_sel_out;
    logic [31:0]            offset_out;
    logic                   out_en_out;
    logic                   update_out;
    logic                   busy_out;
    int                     err_total = 0;
    int                     checked = 0;
    int                     seed = 72;
    int                     cyc = 0;
    int                     last_cyc = 0;
    int                     last_gap = 0;
    logic [3:0]             cur_sel = 4'h9;
    logic                   off_due = 1'b0;
    logic [31:0]            off_exp = 32'h0;
    logic [25:0]            w_q [$];
    logic [31:0]            off_q [$];
    logic [15:0]            rd_q [$];

    always #5 clock_in = ~clock_in;

    dfpc_host #(.PACE(PACE)) i_dfpc_host (.clock_in(clock_in), .req_out(req));

    dfpc_top #(.FACTORY_RANGE(4'h9), .PACE_CYCLES(PACE)) i_dfpc_top (
        .clock_in(clock_in), .srst_in(srst_in), .req_in(req),
        .oe_pin_mode_in(oe_pin_mode_in), .oe_pin_in(oe_pin_in),
        .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .word_out(word_out), .range_sel_out(range_sel_out),
        .offset_out(offset_out), .out_en_out(out_en_out),
        .update_out(update_out), .busy_out(busy_out));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // truncation toward zero matches the offset unit choice
    function automatic logic [31:0] exp_off(input logic [25:0] w,
                                            input logic [3:0] s);
        longint v;
        v = longint'($signed(w)) * HR[s] * 100;
        return 32'(v / 33554431);
    endfunction

    task automatic send(input logic [25:0] w, input logic oe);
        w_q.push_back(w);
        off_q.push_back(exp_off(w, cur_sel));
        i_dfpc_host.word(w, oe);
    endtask

    task automatic rd(input logic [1:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        i_dfpc_host.get(a);
        i_dfpc_host.idle();
    endtask

    task automatic pick(input logic [3:0] s);
        cur_sel = s;
        i_dfpc_host.put(dfpc_pkg::ADDR_RANGE_SEL, {12'h000, s});
        i_dfpc_host.idle();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    //------------------------------------------------------------
    // result monitor
    //------------------------------------------------------------
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        off_due <= 1'b0;
        if (off_due) chk(offset_out, off_exp, "offset");
        if (update_out === 1'b1) begin
            last_gap <= cyc - last_cyc;
            last_cyc <= cyc;
            chk(32'(busy_out), 1, "busy on update");
            if (w_q.size() == 0) chk(1, 0, "stray update");
            else begin
                chk(32'(word_out), 32'(w_q.pop_front()), "word");
                chk(32'(range_sel_out), 32'(cur_sel), "range");
                off_exp <= off_q.pop_front();
                off_due <= 1'b1;
            end
        end
        if (rvalid_out === 1'b1) begin
            if (rd_q.size() == 0) chk(1, 0, "stray read");
            else chk(32'(rdata_out), 32'(rd_q.pop_front()), "rdata");
        end
    end

    initial begin
        tick(20000);
        chk(1, 0, "timeout");
        test_done();
    end

    initial begin
        repeat (10) @(posedge clock_in);
        srst_in <= 1'b0;
        tick(1);
        chk(32'(word_out), 0, "reset word");
        chk(32'(range_sel_out), 32'h9, "factory range");
        chk(offset_out, 0, "reset offset");
        rd(2'h0, 16'h0000);
        rd(2'h2, 16'h0009);
        i_dfpc_host.put(dfpc_pkg::ADDR_WORD_LOW, 16'hBEEF);
        i_dfpc_host.idle();
        tick(PACE + 4);
        chk(32'(word_out), 0, "low only");
        chk(32'(busy_out), 0, "idle after low");
        send({10'h155, 16'hBEEF}, 1'b1);
        chk(32'(out_en_out), 1, "soft enable");
        rd(2'h1, {5'h00, 1'b1, 10'h155});
        rd(2'h3, 16'h0000);
        @(posedge clock_in);
        oe_pin_mode_in <= 1'b1;
        send({10'h2AA, 16'h1234}, 1'b0);
        chk(32'(out_en_out), 0, "pin low");
        rd(2'h1, {5'h00, 1'b1, 10'h2AA});
        @(posedge clock_in);
        oe_pin_in <= 1'b1;
        tick(3);
        chk(32'(out_en_out), 1, "pin high");
        @(posedge clock_in);
        oe_pin_mode_in <= 1'b0;
        for (int r = 0; r < 16; r++) begin
            pick(4'(r));
            rd(2'h2, {12'h000, 4'(r)});
            send(26'($random(seed)), 1'b1);
        end
        send(26'h1FFFFFF, 1'b1);
        send(26'h2000000, 1'b1);
        pick(4'h0);
        send(26'h2000000, 1'b1);
        // second high write lands inside the pacing window
        i_dfpc_host.put(dfpc_pkg::ADDR_WORD_LOW, 16'h0F0F);
        send({10'h0AA, 16'h0F0F}, 1'b1);
        w_q.push_back({10'h0AA, 16'h0F0F});
        off_q.push_back(exp_off({10'h0AA, 16'h0F0F}, cur_sel));
        i_dfpc_host.put(dfpc_pkg::ADDR_WORD_HIGH, 16'h04AA);
        w_q.push_back({10'h0AA, 16'h0F0F});
        i_dfpc_host.put(dfpc_pkg::ADDR_WORD_HIGH, 16'h0555);
        i_dfpc_host.idle();
        w_q.delete(w_q.size() - 1);
        w_q.push_back({10'h155, 16'h0F0F});
        off_q.push_back(exp_off({10'h155, 16'h0F0F}, cur_sel));
        tick(3 * PACE + 6);
        chk(32'(last_gap), PACE, "pacing gap");
        @(posedge clock_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        cur_sel = 4'h9;
        tick(2);
        chk(32'(word_out), 0, "rereset word");
        chk(32'(range_sel_out), 32'h9, "rereset range");
        chk(32'(w_q.size()), 0, "missing update");
        test_done();
    end
endmodule // tb

`default_nettype wire
